// ==== csfr_pkg.sv ====
// Constants and types for the processor status flag register block
// What this block does
// - Status register accepts any instruction as its destination.
// - Flag-setting op into status: written flags dropped, ALU flags kept.
// - Watchdog and power-down bits ignore every software write.
// - Clear of status zeroes upper three bits, sets zero flag.
// - Bit 7 picks indirect bank pair: one gives banks 2-3, zero 0-1.
// - Bits 6-5 pick direct bank 0 to 3 in 128-byte steps.
// - Bit 4 set by reset, watchdog kick or sleep; cleared by time-out.
// - Bit 3 set by reset or watchdog kick; cleared by sleep.
// - Bit 2 set when an arithmetic or logic result is zero.
// - Bit 1 set on carry out of the low nibble for add and subtract.
// - Bit 0 set on carry out of the top bit for add and subtract.
// - Subtract adds two's complement; carries act as active-low borrows.
// - Rotates load carry with the bit shifted out of the source.
package csfr_pkg;

  // Bus register offsets (byte addresses)
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_RESULT = 4'h4;

  // Status bit positions
  localparam int BIT_INDIRECT = 7;
  localparam int BIT_DIRECT_HI = 6;
  localparam int BIT_DIRECT_LO = 5;
  localparam int BIT_EXPIRED_N = 4;
  localparam int BIT_SLEEP_N = 3;
  localparam int BIT_ZERO = 2;
  localparam int BIT_NIBBLE = 1;
  localparam int BIT_CARRY = 0;

  // Reset values; arithmetic flags are don't-care, held at zero
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Mask of the software-writable status bits
  localparam logic [7:0] SW_WRITE_MASK = 8'hE7;
  localparam logic [7:0] FLAG_MASK = 8'h07;
  localparam logic [7:0] BANK_MASK = 8'hE0;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Core instruction classes
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000,
    OP_ADD = 4'b0001,
    OP_SUB = 4'b0010,
    OP_AND = 4'b0011,
    OP_IOR = 4'b0100,
    OP_XOR = 4'b0101,
    OP_ROT_LEFT = 4'b0110,
    OP_ROT_RIGHT = 4'b0111,
    OP_CLEAR = 4'b1000,
    OP_SWAP = 4'b1001,
    OP_PASS = 4'b1010,
    OP_KICK = 4'b1011,
    OP_SLEEP = 4'b1100
  } csfr_op_t;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RESP = 2'b01
  } csfr_bus_t;

endpackage

// ==== csfr_alu_flags.sv ====
// Combinational result and flag computation for core operations
`timescale 1ns/1ps
module csfr_alu_flags (
  // Operation
  input wire csfr_pkg::csfr_op_t op,
  input wire logic [7:0] opnd_a,
  input wire logic [7:0] opnd_b,
  input wire logic carry_in,
  // Results
  output logic [7:0] result,
  output logic zero_flag,
  output logic nibble_carry_flag,
  output logic carry_flag,
  output logic upd_zero,
  output logic upd_arith,
  output logic upd_carry,
  output logic writes_dest
);

  // Subtract as a plus two's complement of b, so carries become borrows
  wire logic [7:0] addend = (op == csfr_pkg::OP_SUB) ? ~opnd_b : opnd_b;
  wire logic cin = (op == csfr_pkg::OP_SUB);
  wire logic [8:0] sum9 = {1'b0, opnd_a} + {1'b0, addend} + {8'h00, cin};
  wire logic [4:0] sum5 = {1'b0, opnd_a[3:0]} + {1'b0, addend[3:0]}
    + {4'h0, cin};
  wire logic is_arith = (op == csfr_pkg::OP_ADD) || (op == csfr_pkg::OP_SUB);

  always_comb begin
    result = opnd_b;
    carry_flag = sum9[8];
    nibble_carry_flag = sum5[4];
    upd_arith = is_arith;
    upd_carry = is_arith;
    upd_zero = 1'b1;
    writes_dest = 1'b1;
    case (op)
      csfr_pkg::OP_ADD,
      csfr_pkg::OP_SUB: result = sum9[7:0];
      csfr_pkg::OP_AND: result = opnd_a & opnd_b;
      csfr_pkg::OP_IOR: result = opnd_a | opnd_b;
      csfr_pkg::OP_XOR: result = opnd_a ^ opnd_b;
      csfr_pkg::OP_ROT_LEFT: begin
        result = {opnd_a[6:0], carry_in};
        carry_flag = opnd_a[7];
        upd_carry = 1'b1;
        upd_zero = 1'b0;
      end
      csfr_pkg::OP_ROT_RIGHT: begin
        result = {carry_in, opnd_a[7:1]};
        carry_flag = opnd_a[0];
        upd_carry = 1'b1;
        upd_zero = 1'b0;
      end
      csfr_pkg::OP_CLEAR: result = 8'h00;
      csfr_pkg::OP_SWAP: begin
        result = {opnd_a[3:0], opnd_a[7:4]};
        upd_zero = 1'b0;
      end
      csfr_pkg::OP_PASS: upd_zero = 1'b0;
      default: begin
        upd_zero = 1'b0;
        writes_dest = 1'b0;
      end
    endcase
    zero_flag = (result == 8'h00);
  end

endmodule // csfr_alu_flags

// ==== csfr_top.sv ====
// Status flag register with core port and AXI4-Lite register access
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module csfr_top #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 32
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Core instruction port
  input wire logic instr_valid,
  input wire csfr_pkg::csfr_op_t instr_op,
  input wire logic [7:0] instr_opnd_a,
  input wire logic [7:0] instr_opnd_b,
  input wire logic instr_dest_status,
  // Watchdog event
  input wire logic watchdog_timeout,
  // Core results
  output logic [7:0] result_out,
  output logic result_valid,
  // Status and bank selects
  output logic [7:0] status_out,
  output logic indirect_page_sel,
  output logic [1:0] direct_page_sel
);

  // Elaboration check on bus geometry
  if (DATA_W != 32 || ADDR_W < 3) begin : g_bad_params
    $error("csfr_top: DATA_W must be 32 and ADDR_W at least 3");
  end

  // Registers
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] result_reg;
  logic result_valid_reg;

  // Bus slave registers
  logic aw_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_full_reg;
  logic [7:0] w_data_reg;
  logic w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  csfr_pkg::csfr_bus_t rd_state_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Flag unit outputs
  logic [7:0] alu_result;
  logic alu_zero;
  logic alu_nibble;
  logic alu_carry;
  logic alu_upd_zero;
  logic alu_upd_arith;
  logic alu_upd_carry;
  logic alu_writes_dest;

  csfr_alu_flags u_flags (
    .op(instr_op),
    .opnd_a(instr_opnd_a),
    .opnd_b(instr_opnd_b),
    .carry_in(status_reg[csfr_pkg::BIT_CARRY]),
    .result(alu_result),
    .zero_flag(alu_zero),
    .nibble_carry_flag(alu_nibble),
    .carry_flag(alu_carry),
    .upd_zero(alu_upd_zero),
    .upd_arith(alu_upd_arith),
    .upd_carry(alu_upd_carry),
    .writes_dest(alu_writes_dest)
  );

  // Core side decode
  wire logic core_op = instr_valid && (instr_op != csfr_pkg::OP_NONE);
  wire logic core_dest_wr = core_op && alu_writes_dest && instr_dest_status;
  wire logic kick_evt = instr_valid && (instr_op == csfr_pkg::OP_KICK);
  wire logic sleep_evt = instr_valid && (instr_op == csfr_pkg::OP_SLEEP);

  // Bus write decode
  wire logic aw_take = awvalid && awready_reg;
  wire logic w_take = wvalid && wready_reg;
  wire logic wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  // Word index compare works for any address width of 3 or more
  wire logic [ADDR_W-1:0] aw_word = aw_addr_reg >> 2;
  wire logic [ADDR_W-1:0] ar_word = araddr >> 2;
  wire logic [ADDR_W-1:0] status_word = ADDR_W'(csfr_pkg::OFS_STATUS >> 2);
  wire logic [ADDR_W-1:0] result_word = ADDR_W'(csfr_pkg::OFS_RESULT >> 2);
  wire logic wr_hit_status = (aw_word == status_word);
  wire logic wr_hit_result = (aw_word == result_word);
  wire logic wr_mapped = wr_hit_status || wr_hit_result;
  // A bus write acts as a flag-free move into the register
  wire logic bus_status_wr = wr_fire && wr_hit_status && w_strb_reg;

  // Bus read decode
  wire logic ar_take = arvalid && arready_reg;
  wire logic rd_hit_status = (ar_word == status_word);
  wire logic rd_hit_result = (ar_word == result_word);
  // Any flag-setting op discards all three written flag bits
  wire logic alu_sets_flags = alu_upd_zero || alu_upd_arith || alu_upd_carry;
  wire logic [7:0] core_wr_mask = alu_sets_flags
    ? (csfr_pkg::SW_WRITE_MASK & ~csfr_pkg::FLAG_MASK)
    : csfr_pkg::SW_WRITE_MASK;
  wire logic [DATA_W-1:0] rd_word = rd_hit_status
    ? {{(DATA_W-8){1'b0}}, status_reg}
    : rd_hit_result ? {{(DATA_W-8){1'b0}}, result_reg}
    : {DATA_W{1'b0}};
  wire logic [1:0] rd_resp = (rd_hit_status || rd_hit_result)
    ? csfr_pkg::RESP_OKAY : csfr_pkg::RESP_SLVERR;

  // Next status value; core write beats a same-cycle bus write
  always_comb begin
    status_next = status_reg;
    if (core_dest_wr) begin
      // Status takes results like any destination register
      status_next = (status_reg & ~core_wr_mask)
        | (alu_result & core_wr_mask);
    end else if (bus_status_wr) begin
      status_next = (status_reg & ~csfr_pkg::SW_WRITE_MASK)
        | (w_data_reg & csfr_pkg::SW_WRITE_MASK);
    end
    // Hardware flag results override any written flag bits
    if (core_op && alu_upd_zero) begin
      status_next[csfr_pkg::BIT_ZERO] = alu_zero;
    end
    if (core_op && alu_upd_arith) begin
      status_next[csfr_pkg::BIT_NIBBLE] = alu_nibble;
    end
    if (core_op && alu_upd_carry) begin
      status_next[csfr_pkg::BIT_CARRY] = alu_carry;
    end
    // Time-out and power-down bits change only on hardware events
    if (kick_evt) begin
      status_next[csfr_pkg::BIT_EXPIRED_N] = 1'b1;
      status_next[csfr_pkg::BIT_SLEEP_N] = 1'b1;
    end else if (sleep_evt) begin
      status_next[csfr_pkg::BIT_EXPIRED_N] = 1'b1;
      status_next[csfr_pkg::BIT_SLEEP_N] = 1'b0;
    end
    // Time-out last so a real expiry is never masked by a kick
    if (watchdog_timeout) begin
      status_next[csfr_pkg::BIT_EXPIRED_N] = 1'b0;
    end
  end

  // Status register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= csfr_pkg::STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Result of the last writing instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= csfr_pkg::RESULT_RESET;
      result_valid_reg <= 1'b0;
    end else begin
      result_valid_reg <= core_op && alu_writes_dest;
      if (core_op && alu_writes_dest) begin
        result_reg <= alu_result;
      end
    end
  end

  // Write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_take) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  // Write data holding; only the low byte lane carries the register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= 8'h00;
      w_strb_reg <= 1'b0;
    end else if (w_take) begin
      w_full_reg <= 1'b1;
      w_data_reg <= wdata[7:0];
      w_strb_reg <= wstrb[0];
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  // Ready lowers once a beat is held, so nothing is taken twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      awready_reg <= !(aw_take || (aw_full_reg && !wr_fire));
      wready_reg <= !(w_take || (w_full_reg && !wr_fire));
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= csfr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_mapped ? csfr_pkg::RESP_OKAY : csfr_pkg::RESP_SLVERR;
    end else if (bvalid_reg && bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read channel: one read in flight, data sampled at address accept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= csfr_pkg::BUS_IDLE;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= csfr_pkg::RESP_OKAY;
    end else begin
      case (rd_state_reg)
        csfr_pkg::BUS_IDLE: begin
          arready_reg <= !ar_take;
          if (ar_take) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_resp;
            rd_state_reg <= csfr_pkg::BUS_RESP;
          end
        end
        csfr_pkg::BUS_RESP: begin
          if (rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
            rd_state_reg <= csfr_pkg::BUS_IDLE;
          end
        end
        default: begin
          rd_state_reg <= csfr_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign result_out = result_reg;
  assign result_valid = result_valid_reg;
  assign status_out = status_reg;
  assign indirect_page_sel = status_reg[csfr_pkg::BIT_INDIRECT];
  assign direct_page_sel = status_reg[csfr_pkg::BIT_DIRECT_HI:
    csfr_pkg::BIT_DIRECT_LO];

endmodule // csfr_top

// ==== csfr_top_props.sv ====
// Checker of status register behaviour at the block ports
`timescale 1ns/1ps
module csfr_top_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core side
  input wire logic instr_valid,
  input wire csfr_pkg::csfr_op_t instr_op,
  input wire logic [7:0] instr_opnd_a,
  input wire logic [7:0] instr_opnd_b,
  input wire logic instr_dest_status,
  input wire logic watchdog_timeout,
  // Status view
  input wire logic [7:0] status_out,
  input wire logic indirect_page_sel,
  input wire logic [1:0] direct_page_sel
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Subtract as add of the two's complement
  wire logic [8:0] add9 = {1'b0, instr_opnd_a} + {1'b0, instr_opnd_b};
  wire logic [4:0] add5 = {1'b0, instr_opnd_a[3:0]}
    + {1'b0, instr_opnd_b[3:0]};
  wire logic [8:0] sub9 = {1'b0, instr_opnd_a} + {1'b0, ~instr_opnd_b}
    + 9'h001;
  wire logic [4:0] sub5 = {1'b0, instr_opnd_a[3:0]}
    + {1'b0, ~instr_opnd_b[3:0]} + 5'h01;
  wire logic [2:0] add_f = {add9[7:0] == 8'h00, add5[4], add9[8]};
  wire logic [2:0] sub_f = {sub9[7:0] == 8'h00, sub5[4], sub9[8]};
  wire logic rot_c = (instr_op == csfr_pkg::OP_ROT_LEFT) ? instr_opnd_a[7]
    : instr_opnd_a[0];
  wire logic go = instr_valid && !watchdog_timeout;
  wire logic evt = instr_valid && (instr_op == csfr_pkg::OP_KICK
    || instr_op == csfr_pkg::OP_SLEEP);

  reset_value_a: assert property (
    $rose(aresetn) |-> status_out[7:3] == 5'h03)
    else $error("bank or reset bits wrong after reset");
  page_sel_a: assert property (
    {indirect_page_sel, direct_page_sel} == status_out[7:5])
    else $error("bank selects differ from status");
  kick_bits_a: assert property (
    go && instr_op == csfr_pkg::OP_KICK |=> status_out[4:3] == 2'h3)
    else $error("kick did not set reset bits");
  sleep_bits_a: assert property (
    go && instr_op == csfr_pkg::OP_SLEEP |=> status_out[4:3] == 2'h2)
    else $error("sleep gave wrong reset bits");
  timeout_clr_a: assert property (
    watchdog_timeout |=> !status_out[4])
    else $error("time-out did not clear bit 4");
  bits_locked_a: assert property (
    !watchdog_timeout && !evt |=> $stable(status_out[4:3]))
    else $error("reset bits changed without event");
  clear_status_a: assert property (
    instr_valid && instr_op == csfr_pkg::OP_CLEAR && instr_dest_status
    |=> status_out[7:5] == 3'h0 && status_out[2]
    && status_out[1:0] == $past(status_out[1:0]))
    else $error("clear of status gave wrong value");
  add_flags_a: assert property (
    instr_valid && instr_op == csfr_pkg::OP_ADD
    |=> status_out[2:0] == $past(add_f))
    else $error("add flags wrong");
  sub_flags_a: assert property (
    instr_valid && instr_op == csfr_pkg::OP_SUB
    |=> status_out[2:0] == $past(sub_f))
    else $error("subtract flags wrong");
  rot_carry_a: assert property (
    instr_valid && (instr_op == csfr_pkg::OP_ROT_LEFT
    || instr_op == csfr_pkg::OP_ROT_RIGHT) |=> status_out[0] == $past(rot_c))
    else $error("rotate carry wrong");
endmodule // csfr_top_props

bind csfr_top csfr_top_props u_props (.*);

// ==== csfr_core_model.sv ====
// Model of the core execution path feeding the status block
`timescale 1ns/1ps
module csfr_core_model (
  // Clock
  input wire logic aclk,
  // Instruction stream
  output logic instr_valid,
  output csfr_pkg::csfr_op_t instr_op,
  output logic [7:0] instr_opnd_a,
  output logic [7:0] instr_opnd_b,
  output logic instr_dest_status,
  // Watchdog
  output logic watchdog_timeout
);
  initial begin
    instr_valid = 1'b0;
    instr_op = csfr_pkg::OP_NONE;
    instr_opnd_a = 8'h00;
    instr_opnd_b = 8'h00;
    instr_dest_status = 1'b0;
    watchdog_timeout = 1'b0;
  end
  // Status altered by any writing op with dest set, e.g. move or swap (PASS, SWAP)
  task automatic issue(input csfr_pkg::csfr_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic dest, input logic wdt);
    @(posedge aclk);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_opnd_a <= a;
    instr_opnd_b <= b;
    instr_dest_status <= dest;
    watchdog_timeout <= wdt;
    @(posedge aclk);
    instr_valid <= 1'b0;
    instr_op <= csfr_pkg::OP_NONE;
    // Released operands stop showing the old value
    instr_opnd_a <= ~a;
    instr_opnd_b <= ~b;
    watchdog_timeout <= 1'b0;
    @(negedge aclk);
  endtask
endmodule // csfr_core_model

// ==== csfr_top_bench.sv ====
// Self-checking bench for the status flag register block
`timescale 1ns/1ps
module csfr_top_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, result_valid;
  logic [3:0] awaddr, araddr, wstrb;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs, direct_page_sel;
  logic instr_valid, instr_dest_status, watchdog_timeout, indirect_page_sel;
  csfr_pkg::csfr_op_t instr_op;
  logic [7:0] instr_opnd_a, instr_opnd_b, result_out, status_out;
  int mismatches = 0;
  int tests_run = 0;

  csfr_top u_dut (.*);
  csfr_core_model u_core (.*);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
      output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) aw = 1'b1;
      if (wvalid && wready) w = 1'b1;
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (!(aw && w));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic alu(input csfr_pkg::csfr_op_t op, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] res, input logic [2:0] fl);
    u_core.issue(op, a, b, 1'b0, 1'b0);
    chk("result", res, result_out);
    chk("result valid", 8'h01, {7'h00, result_valid});
    chk("flags", {5'h00, fl}, {5'h00, status_out[2:0]});
  endtask

  task automatic t_reset_bank();
    axi_rd(4'h0, rd, rs);
    chk("reset status", 8'h18, rd[7:0] & 8'hF8);
    for (int i = 0; i < 8; i++) begin
      axi_wr(4'h0, 32'(i) << 5, rs);
      @(negedge aclk);
      chk("indirect", 8'(i >> 2), {7'h00, indirect_page_sel});
      chk("direct", 8'(i % 4), {6'h00, direct_page_sel});
      chk("locked bits", 8'h03, {6'h00, status_out[4:3]});
    end
    $display("t_reset_bank done");
  endtask

  task automatic t_arith();
    alu(csfr_pkg::OP_ADD, 8'hF8, 8'h08, 8'h00, 3'h7);
    alu(csfr_pkg::OP_ADD, 8'h01, 8'h01, 8'h02, 3'h0);
    alu(csfr_pkg::OP_SUB, 8'h05, 8'h05, 8'h00, 3'h7);
    alu(csfr_pkg::OP_SUB, 8'h03, 8'h05, 8'hFE, 3'h0);
    alu(csfr_pkg::OP_SUB, 8'h10, 8'h01, 8'h0F, 3'h1);
    u_core.issue(csfr_pkg::OP_ADD, 8'h0F, 8'h01, 1'b1, 1'b0);
    chk("flag dest", 8'h1A, status_out);
    alu(csfr_pkg::OP_AND, 8'hF0, 8'h0F, 8'h00, 3'h6);
    u_core.issue(csfr_pkg::OP_ROT_LEFT, 8'h80, 8'h00, 1'b0, 1'b0);
    chk("rotate carry", 8'h07, status_out & 8'h07);
    u_core.issue(csfr_pkg::OP_ROT_RIGHT, 8'h02, 8'h00, 1'b0, 1'b0);
    chk("rotate carry", 8'h06, status_out & 8'h07);
    u_core.issue(csfr_pkg::OP_ROT_RIGHT, 8'h01, 8'h00, 1'b0, 1'b0);
    chk("rotate carry", 8'h07, status_out & 8'h07);
    $display("t_arith done");
  endtask

  task automatic t_clear_events();
    axi_wr(4'h0, 32'h0000_00E3, rs);
    u_core.issue(csfr_pkg::OP_CLEAR, 8'h55, 8'h55, 1'b1, 1'b0);
    chk("clear status", 8'h1F, status_out);
    u_core.issue(csfr_pkg::OP_PASS, 8'h00, 8'hA5, 1'b1, 1'b0);
    chk("move status", 8'hBD, status_out);
    u_core.issue(csfr_pkg::OP_SLEEP, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("sleep bits", 8'h02, {6'h00, status_out[4:3]});
    u_core.issue(csfr_pkg::OP_NONE, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("timeout bits", 8'h00, {6'h00, status_out[4:3]});
    u_core.issue(csfr_pkg::OP_KICK, 8'h00, 8'h00, 1'b0, 1'b1);
    chk("kick timeout", 8'h01, {6'h00, status_out[4:3]});
    u_core.issue(csfr_pkg::OP_KICK, 8'h00, 8'h00, 1'b0, 1'b0);
    chk("kick bits", 8'h03, {6'h00, status_out[4:3]});
    $display("t_clear_events done");
  endtask

  task automatic t_bus();
    axi_rd(4'h8, rd, rs);
    chk("unmapped rd", 8'h02, {6'h00, rs});
    chk("unmapped data", 8'h00, rd[7:0]);
    axi_wr(4'hC, 32'h0000_00FF, rs);
    chk("unmapped wr", 8'h02, {6'h00, rs});
    axi_wr(4'h4, 32'h0000_00FF, rs);
    chk("result wr", 8'h00, {6'h00, rs});
    axi_rd(4'h0, rd, rs);
    chk("status kept", 8'hBD, rd[7:0]);
    $display("t_bus done");
  endtask

  task automatic give_verdict();
    $display("%0d checks, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Whole run is under two hundred cycles; reaching 5000 cycles means a hang
  initial begin
    repeat (5000) @(posedge aclk);
    mismatches++;
    give_verdict();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    awprot = 3'h0;
    arprot = 3'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_bank();
    t_arith();
    t_clear_events();
    t_bus();
    give_verdict();
  end
endmodule // csfr_top_bench
